/* File: core/pts_pkg.sv */
// package of constants and types for the program trace sync message generator
// assumes a single core clock domain and an asynchronous active-high reset
// Notes on behaviour
// - After any reset with instruction trace on, the first program trace message is a sync message.
// - The sync message carries the full execution address and the instruction count.
// - The instruction count holds instructions since the last message and restarts when one is sent.
// - With branch history on, count and history both clear when the post-reset sync is sent.
// - Direct-branch-with-sync and indirect-branch-history-with-sync variants also resynchronise.
// - An indirect branch sends a message that clears the count, and the history in history mode.
// - A direct-branch-with-sync message is forced on the 256th consecutive direct branch.
// - In history mode the indirect message carries the taken history, cleared when sent.
package pts_pkg;
    localparam int ADDR_W     = 32;
    localparam int INSTRUCTION_COUNT_FIELD_W     = 16;
    localparam int BRANCH_HISTORY_FIELD_W     = 32;
    localparam int DIRECT_MAX = 256;
    localparam int DCNT_W     = 9;

    typedef enum logic [2:0] {
        PTS_MSG_SYNC,
        PTS_MSG_DIRECT,
        PTS_MSG_DIRECT_SYNC,
        PTS_MSG_INDIRECT,
        PTS_MSG_INDIRECT_SYNC
    } pts_msg_t;
endpackage

/* File: core/pts_if.sv */
// interface carrying one trace message from the generator to its output stage
// assumes producer and consumer share mclk_in
`timescale 1ns/1ns
interface pts_msg_if;
    logic                        valid;
    logic                        ready;
    pts_pkg::pts_msg_t           kind;
    logic [pts_pkg::ADDR_W-1:0]  addr;
    logic [pts_pkg::INSTRUCTION_COUNT_FIELD_W-1:0]  instruction_count_field;
    logic [pts_pkg::BRANCH_HISTORY_FIELD_W-1:0]  branch_history_field;
    modport src (output valid, kind, addr, instruction_count_field, branch_history_field, input ready);
    modport dst (input valid, kind, addr, instruction_count_field, branch_history_field, output ready);
endinterface

/* File: core/pts_out_stage.sv */
// output register stage holding one trace message until the tool side takes it
// assumes consumer ready comes from logic on mclk_in
`timescale 1ns/1ns
module pts_out_stage (
    input  wire logic               mclk_in,
    input  wire logic               reset_in,
    pts_msg_if.dst                  msg,
    input  wire logic               take_in,
    output logic                    valid_out,
    output pts_pkg::pts_msg_t       kind_out,
    output logic [pts_pkg::ADDR_W-1:0] addr_out,
    output logic [pts_pkg::INSTRUCTION_COUNT_FIELD_W-1:0] instruction_count_field_out,
    output logic [pts_pkg::BRANCH_HISTORY_FIELD_W-1:0] branch_history_field_out
);
    logic                       valid_next;
    pts_pkg::pts_msg_t          kind_next;
    logic [pts_pkg::ADDR_W-1:0] addr_next;
    logic [pts_pkg::INSTRUCTION_COUNT_FIELD_W-1:0] instruction_count_field_next;
    logic [pts_pkg::BRANCH_HISTORY_FIELD_W-1:0] branch_history_field_next;

    assign msg.ready = !valid_out || take_in;

    always_comb begin
        valid_next = valid_out;
        kind_next  = kind_out;
        addr_next  = addr_out;
        instruction_count_field_next  = instruction_count_field_out;
        branch_history_field_next  = branch_history_field_out;
        if (msg.ready) begin
            valid_next = msg.valid;
            if (msg.valid) begin
                kind_next = msg.kind;
                addr_next = msg.addr;
                instruction_count_field_next = msg.instruction_count_field;
                branch_history_field_next = msg.branch_history_field;
            end
        end
    end

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            valid_out <= 1'b0;
            kind_out  <= pts_pkg::PTS_MSG_SYNC;
            addr_out  <= '0;
            instruction_count_field_out  <= '0;
            branch_history_field_out  <= '0;
        end else begin
            valid_out <= valid_next;
            kind_out  <= kind_next;
            addr_out  <= addr_next;
            instruction_count_field_out  <= instruction_count_field_next;
            branch_history_field_out  <= branch_history_field_next;
        end
    end
endmodule

/* File: core/pts_trace_gen.sv */
// program trace message generator: count, history, sync after reset, periodic sync
// assumes the retire inputs come from core logic on mclk_in, one instruction per cycle max
`timescale 1ns/1ns
module pts_trace_gen (
    input  wire logic                       mclk_in,
    input  wire logic                       reset_in,
    input  wire logic                       trace_en_in,
    input  wire logic                       branch_history_field_mode_in,
    input  wire logic                       retire_in,
    input  wire logic [pts_pkg::ADDR_W-1:0] retire_addr_in,
    input  wire logic                       direct_br_in,
    input  wire logic                       indirect_br_in,
    input  wire logic                       br_taken_in,
    input  wire logic                       take_in,
    output logic                            stall_out,
    output logic                            msg_valid_out,
    output pts_pkg::pts_msg_t               msg_kind_out,
    output logic [pts_pkg::ADDR_W-1:0]      msg_addr_out,
    output logic [pts_pkg::INSTRUCTION_COUNT_FIELD_W-1:0]      msg_instruction_count_field_out,
    output logic [pts_pkg::BRANCH_HISTORY_FIELD_W-1:0]      msg_branch_history_field_out
);
    pts_msg_if msg ();

    logic                        need_sync_reg;
    logic                        need_sync_next;
    logic [pts_pkg::INSTRUCTION_COUNT_FIELD_W-1:0]  instruction_count_field_reg;
    logic [pts_pkg::INSTRUCTION_COUNT_FIELD_W-1:0]  instruction_count_field_next;
    logic [pts_pkg::BRANCH_HISTORY_FIELD_W-1:0]  branch_history_field_reg;
    logic [pts_pkg::BRANCH_HISTORY_FIELD_W-1:0]  branch_history_field_next;
    logic [pts_pkg::DCNT_W-1:0]  dcnt_reg;
    logic [pts_pkg::DCNT_W-1:0]  dcnt_next;
    logic                        ev;
    logic                        fire;
    logic                        period_sync;
    logic [pts_pkg::INSTRUCTION_COUNT_FIELD_W-1:0]  instruction_count_field_inc;
    logic [pts_pkg::BRANCH_HISTORY_FIELD_W-1:0]  branch_history_field_acc;

    localparam logic [pts_pkg::DCNT_W-1:0] DCNT_LAST =
        pts_pkg::DCNT_W'(pts_pkg::DIRECT_MAX - 1);

    // a retiring instruction needs a message slot when it branches or a sync is due
    assign ev          = trace_en_in && retire_in;
    assign period_sync = direct_br_in && (dcnt_reg == DCNT_LAST);
    assign fire        = ev && (need_sync_reg || indirect_br_in || direct_br_in);
    assign stall_out   = fire && !msg.ready;
    assign instruction_count_field_inc    = instruction_count_field_reg + pts_pkg::INSTRUCTION_COUNT_FIELD_W'(1);
    assign branch_history_field_acc    = {branch_history_field_reg[pts_pkg::BRANCH_HISTORY_FIELD_W-2:0], br_taken_in};

    always_comb begin
        msg.valid = fire;
        msg.addr  = retire_addr_in;
        msg.instruction_count_field  = instruction_count_field_inc;
        // only a direct branch adds its taken bit to the history
        msg.branch_history_field  = branch_history_field_mode_in ? (direct_br_in ? branch_history_field_acc : branch_history_field_reg) : '0;
        if (need_sync_reg && !direct_br_in && !indirect_br_in)
            msg.kind = pts_pkg::PTS_MSG_SYNC;
        else if (indirect_br_in)
            msg.kind = (need_sync_reg || period_sync) ? pts_pkg::PTS_MSG_INDIRECT_SYNC
                                                      : pts_pkg::PTS_MSG_INDIRECT;
        else if (need_sync_reg || period_sync)
            msg.kind = pts_pkg::PTS_MSG_DIRECT_SYNC;
        else
            msg.kind = pts_pkg::PTS_MSG_DIRECT;
    end

    always_comb begin
        need_sync_next = need_sync_reg;
        instruction_count_field_next      = instruction_count_field_reg;
        branch_history_field_next      = branch_history_field_reg;
        dcnt_next      = dcnt_reg;
        if (!trace_en_in) begin
            need_sync_next = 1'b1;
        end else if (ev && !stall_out) begin
            instruction_count_field_next = instruction_count_field_inc;
            if (direct_br_in && branch_history_field_mode_in)
                branch_history_field_next = branch_history_field_acc;
            if (fire) begin
                need_sync_next = 1'b0;
                instruction_count_field_next      = '0;
                branch_history_field_next      = '0;
                if (need_sync_reg || indirect_br_in || period_sync)
                    dcnt_next = '0;
                else
                    dcnt_next = dcnt_reg + pts_pkg::DCNT_W'(1);
            end
        end
    end

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            need_sync_reg <= 1'b1;
            instruction_count_field_reg      <= '0;
            branch_history_field_reg      <= '0;
            dcnt_reg      <= '0;
        end else begin
            need_sync_reg <= need_sync_next;
            instruction_count_field_reg      <= instruction_count_field_next;
            branch_history_field_reg      <= branch_history_field_next;
            dcnt_reg      <= dcnt_next;
        end
    end

    pts_out_stage u_out (
        .mclk_in   (mclk_in),
        .reset_in  (reset_in),
        .msg       (msg),
        .take_in   (take_in),
        .valid_out (msg_valid_out),
        .kind_out  (msg_kind_out),
        .addr_out  (msg_addr_out),
        .instruction_count_field_out  (msg_instruction_count_field_out),
        .branch_history_field_out  (msg_branch_history_field_out)
    );

    property p_first_sync;
        @(posedge mclk_in) disable iff (reset_in)
        (fire && !stall_out && need_sync_reg) |-> msg.kind != pts_pkg::PTS_MSG_DIRECT
            && msg.kind != pts_pkg::PTS_MSG_INDIRECT;
    endproperty
    a_first_sync: assert property (p_first_sync) else $error("first message not sync");

    property p_addr;
        @(posedge mclk_in) disable iff (reset_in)
        (fire && !stall_out) |=> msg_valid_out && msg_addr_out == $past(retire_addr_in);
    endproperty
    a_addr: assert property (p_addr) else $error("message address wrong");

    property p_instruction_count_field_clr;
        @(posedge mclk_in) disable iff (reset_in)
        (fire && !stall_out && trace_en_in) |=> instruction_count_field_reg == '0;
    endproperty
    a_instruction_count_field_clr: assert property (p_instruction_count_field_clr) else $error("count not cleared");

    property p_instruction_count_field_step;
        @(posedge mclk_in) disable iff (reset_in)
        (ev && !fire && trace_en_in) |=> instruction_count_field_reg == $past(instruction_count_field_reg) + 16'h0001;
    endproperty
    a_instruction_count_field_step: assert property (p_instruction_count_field_step) else $error("count did not step");

    property p_branch_history_field_clr;
        @(posedge mclk_in) disable iff (reset_in)
        (fire && !stall_out && trace_en_in) |=> branch_history_field_reg == '0;
    endproperty
    a_branch_history_field_clr: assert property (p_branch_history_field_clr) else $error("history not cleared");

    property p_ind_kind;
        @(posedge mclk_in) disable iff (reset_in)
        (fire && indirect_br_in) |-> (msg.kind == pts_pkg::PTS_MSG_INDIRECT
            || msg.kind == pts_pkg::PTS_MSG_INDIRECT_SYNC);
    endproperty
    a_ind_kind: assert property (p_ind_kind) else $error("indirect kind wrong");

    property p_period;
        @(posedge mclk_in) disable iff (reset_in)
        (fire && direct_br_in && !indirect_br_in && dcnt_reg == DCNT_LAST)
            |-> msg.kind == pts_pkg::PTS_MSG_DIRECT_SYNC;
    endproperty
    a_period: assert property (p_period) else $error("no forced sync");

    property p_dcnt_bound;
        @(posedge mclk_in) disable iff (reset_in)
        1'b1 |-> dcnt_reg <= DCNT_LAST;
    endproperty
    a_dcnt_bound: assert property (p_dcnt_bound) else $error("direct count overrun");

    property p_branch_history_field_payload;
        @(posedge mclk_in) disable iff (reset_in)
        (fire && branch_history_field_mode_in) |-> msg.branch_history_field == (direct_br_in ? branch_history_field_acc : branch_history_field_reg);
    endproperty
    a_branch_history_field_payload: assert property (p_branch_history_field_payload) else $error("history payload");

    property p_ind_branch_history_field;
        @(posedge mclk_in) disable iff (reset_in)
        (fire && indirect_br_in && !direct_br_in && branch_history_field_mode_in) |-> msg.branch_history_field == branch_history_field_reg;
    endproperty
    a_ind_branch_history_field: assert property (p_ind_branch_history_field) else $error("indirect history wrong");

    property p_ind_sync;
        @(posedge mclk_in) disable iff (reset_in)
        (fire && need_sync_reg && indirect_br_in)
            |-> msg.kind == pts_pkg::PTS_MSG_INDIRECT_SYNC;
    endproperty
    a_ind_sync: assert property (p_ind_sync) else $error("indirect sync variant");

    property p_dir_sync;
        @(posedge mclk_in) disable iff (reset_in)
        (fire && need_sync_reg && direct_br_in && !indirect_br_in)
            |-> msg.kind == pts_pkg::PTS_MSG_DIRECT_SYNC;
    endproperty
    a_dir_sync: assert property (p_dir_sync) else $error("direct sync variant");

    // a held message must stay valid with its address and count unchanged before the tool takes it
    property p_hold;
        @(posedge mclk_in) disable iff (reset_in)
        (msg_valid_out && !take_in) |=> msg_valid_out && $stable(msg_addr_out)
            && $stable(msg_instruction_count_field_out);
    endproperty
    a_hold: assert property (p_hold) else $error("held message changed");

    property p_stall;
        @(posedge mclk_in) disable iff (reset_in)
        stall_out |-> msg_valid_out && !take_in;
    endproperty
    a_stall: assert property (p_stall) else $error("stall without full slot");

    property p_instruction_count_field_payload;
        @(posedge mclk_in) disable iff (reset_in)
        (fire && !stall_out) |=> msg_instruction_count_field_out == $past(instruction_count_field_reg) + 16'h0001;
    endproperty
    a_instruction_count_field_payload: assert property (p_instruction_count_field_payload) else $error("message count wrong");

    c_sync:     cover property (@(posedge mclk_in) fire && msg.kind == pts_pkg::PTS_MSG_SYNC);
    c_period:   cover property (@(posedge mclk_in) fire && period_sync);
    c_ind_sync: cover property (@(posedge mclk_in)
        fire && msg.kind == pts_pkg::PTS_MSG_INDIRECT_SYNC);
    c_stall:    cover property (@(posedge mclk_in) stall_out);
endmodule

/* File: tb/pts_tool.sv */
// trace tool model: takes held messages promptly or with random stalls
// assumes valid_in is the generator's registered message valid
`timescale 1ns/1ns
module pts_tool (
    input  wire logic mclk_in,
    input  wire logic reset_in,
    input  wire logic valid_in,
    input  wire logic slow_in,
    output logic      take_out
);
    integer seed = 11;
    // take a held message at the next edge, or only on random edges while slow_in is high
    always @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            take_out <= 1'b0;
        end else begin
            take_out <= valid_in && (!slow_in || ($random(seed) % 3 == 0));
        end
    end
endmodule

/* File: tb/program_trace_sync_messages_test.sv */
// self-checking bench for pts_trace_gen against a queue model of trace messages
// assumes pts_pkg and the tool model pts_tool are compiled first
`timescale 1ns/1ns
module program_trace_sync_messages_test;
    logic              mclk_in = 1'b0;
    logic              reset_in = 1'b1;
    logic              trace_en_in = 1'b0;
    logic              branch_history_field_mode_in = 1'b1;
    logic              retire_in = 1'b0;
    logic [31:0]       retire_addr_in = 32'h0;
    logic              direct_br_in = 1'b0;
    logic              indirect_br_in = 1'b0;
    logic              br_taken_in = 1'b0;
    logic              take_in;
    logic              slow = 1'b0;
    logic              stall_out;
    logic              msg_valid_out;
    pts_pkg::pts_msg_t msg_kind_out;
    logic [31:0]       msg_addr_out;
    logic [15:0]       msg_instruction_count_field_out;
    logic [31:0]       msg_branch_history_field_out;
    integer            seed = 73676;
    integer            n_errors = 0;
    integer            n_compared = 0;
    integer            cnt, dcnt, i, r;
    logic [31:0]       branch_history_field;
    logic              pend;
    logic [82:0]       e;
    logic [82:0]       q[$];

    pts_trace_gen uut (.mclk_in(mclk_in), .reset_in(reset_in), .trace_en_in(trace_en_in),
        .branch_history_field_mode_in(branch_history_field_mode_in), .retire_in(retire_in), .retire_addr_in(retire_addr_in),
        .direct_br_in(direct_br_in), .indirect_br_in(indirect_br_in),
        .br_taken_in(br_taken_in), .take_in(take_in), .stall_out(stall_out),
        .msg_valid_out(msg_valid_out), .msg_kind_out(msg_kind_out),
        .msg_addr_out(msg_addr_out), .msg_instruction_count_field_out(msg_instruction_count_field_out), .msg_branch_history_field_out(msg_branch_history_field_out));
    pts_tool tool (.mclk_in(mclk_in), .reset_in(reset_in), .valid_in(msg_valid_out),
        .slow_in(slow), .take_out(take_in));

    task automatic finish_test();
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic model(input logic [31:0] a, input logic d, input logic ind, input logic t);
        pts_pkg::pts_msg_t k;
        k = pts_pkg::PTS_MSG_DIRECT;
        if (d && branch_history_field_mode_in) branch_history_field = {branch_history_field[30:0], t};
        if (pend || ind || d) begin
            if (ind) k = pend ? pts_pkg::PTS_MSG_INDIRECT_SYNC : pts_pkg::PTS_MSG_INDIRECT;
            else if (d) begin
                dcnt++;
                if (pend || dcnt == pts_pkg::DIRECT_MAX) k = pts_pkg::PTS_MSG_DIRECT_SYNC;
            end else k = pts_pkg::PTS_MSG_SYNC;
            q.push_back({k, a, 16'(cnt + 1), branch_history_field_mode_in ? branch_history_field : 32'h0});
            if (pend || ind || k == pts_pkg::PTS_MSG_DIRECT_SYNC) dcnt = 0;
            pend = 1'b0; cnt = 0; branch_history_field = 32'h0;
        end else cnt++;
    endtask

    // call at a rising edge; holds the retire until an edge with stall low
    task automatic retire(input logic d, input logic ind);
        logic [31:0] a;
        logic        t;
        int          w;
        a = $random(seed);
        t = $random(seed);
        retire_in <= 1'b1; retire_addr_in <= a; direct_br_in <= d;
        indirect_br_in <= ind; br_taken_in <= t;
        for (w = 0; w < 60; w++) begin
            @(negedge mclk_in);
            if (stall_out === 1'b0) break;
            @(posedge mclk_in);
        end
        if (w == 60) begin n_errors++; finish_test(); end
        @(posedge mclk_in);
        model(a, d, ind, t);
    endtask

    task automatic idle_drain();
        retire_in <= 1'b0;
        for (i = 0; i < 300 && q.size() != 0; i++) @(posedge mclk_in);
        if (q.size() != 0) begin n_errors++; finish_test(); end
        @(posedge mclk_in);
    endtask

    task automatic rand_run(input int n);
        for (r = 0; r < n; r++) begin
            case ($unsigned($random(seed)) % 4)
                0: retire(1'b0, 1'b1);
                1, 2: retire(1'b1, 1'b0);
                default: retire(1'b0, 1'b0);
            endcase
        end
    endtask

    always @(posedge mclk_in) begin
        if (!reset_in && msg_valid_out === 1'b1 && take_in === 1'b1) begin
            if (q.size() == 0) chk(32'h1, 32'h0);
            else begin
                e = q.pop_front();
                chk(32'(msg_kind_out), 32'(e[82:80]));
                chk(msg_addr_out, e[79:48]);
                chk(32'(msg_instruction_count_field_out), 32'(e[47:32]));
                chk(msg_branch_history_field_out, e[31:0]);
            end
        end
    end

    initial begin
        forever #20 mclk_in = ~mclk_in;
    end

    initial begin
        pend = 1'b1; cnt = 0; branch_history_field = 32'h0; dcnt = 0;
        repeat (20) @(posedge mclk_in);
        reset_in <= 1'b0;
        trace_en_in <= 1'b1;
        @(posedge mclk_in);
        rand_run(40);
        slow <= 1'b1;
        rand_run(40);
        idle_drain();
        // periodic sync, no history
        slow <= 1'b0;
        branch_history_field_mode_in <= 1'b0;
        idle_drain();
        for (i = 0; i < 257; i++) retire(1'b1, 1'b0);
        idle_drain();
        // trace off re-arms the sync
        trace_en_in <= 1'b0;
        repeat (3) @(posedge mclk_in);
        trace_en_in <= 1'b1;
        branch_history_field_mode_in <= 1'b1;
        pend = 1'b1;
        @(posedge mclk_in);
        rand_run(20);
        for (i = 0; i < 6; i++) retire(1'b1, 1'b0);
        idle_drain();
        // reset after a drained run, with count and history already clear
        reset_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        reset_in <= 1'b0;
        pend = 1'b1; cnt = 0; branch_history_field = 32'h0; dcnt = 0;
        @(posedge mclk_in);
        retire(1'b1, 1'b0);
        retire(1'b1, 1'b0);
        retire(1'b0, 1'b1);
        retire(1'b0, 1'b1);
        idle_drain();
        finish_test();
    end
endmodule
